// File: rtl/ptsr_pad_test_strap.sv
// pad test readback, pin mode registers and strap vector readback
`timescale 1ns/1ps
`include "ptsr_params.svh"
module ptsr_pad_test_strap (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire ptsr_pkg::ptsr_mgmt_req_t mgmtReq,
  output logic [15:0]                  rdData,
  output logic                         rdValid,
  input  wire logic                    forceCtrl,
  input  wire logic                    forceDirIn,
  input  wire logic [15:0]             padCtrlLo,
  input  wire logic [3:0]              padCtrlHi,
  input  wire logic [19:0]             padIn,
  output logic [19:0]                  padOut,
  output logic [19:0]                  padOe_n,
  input  wire ptsr_pkg::ptsr_strap_t    strapIn,
  input  wire logic                    strapLatch,
  output logic [15:0]                  pinInputMode,
  output logic [15:0]                  pinOutputMode
);
  // pad index: 0..15 follow the low status map, 16..19 the high one
  logic [19:0]           padMeta;        // first sync stage, may go metastable
  logic [19:0]           padSyncA;       // second sync stage
  logic [19:0]           padSyncB;       // third sync stage
  logic [19:0]           padLevel;       // filtered pin level
  logic [15:0]           statusLo;       // low status word
  logic [15:0]           statusHi;       // high status word
  logic                  strapTxShift;   // latched transmit clock shift
  logic                  strapRxShift;   // latched receive clock shift
  logic                  strapSerialEn;  // latched serial mac enable
  logic                  strapReduceEn;  // latched reduced mac enable
  logic [2:0]            strapTestMode;  // latched test mode field
  logic [2:0]            strapMacMode;   // latched mac mode field
  logic                  strapRole;      // latched link role
  logic [4:0]            strapAddr;      // latched management address
  logic [15:0]           strapWord;      // strap fields laid out for reading
  logic                  readbackOn;     // forced input direction
  logic                  driveOn;        // forced output direction
  logic [19:0]           ctrlWord;       // both pad control words side by side
  logic                  selStatusLo;
  logic                  selStatusHi;
  logic                  selInputMode;
  logic                  selOutputMode;
  logic                  selStrapVec;
  logic                  wrInputMode;
  logic                  wrOutputMode;
  logic [15:0]           next_rdData;

  // forced input direction gates the readback path
  assign readbackOn = forceCtrl & forceDirIn;
  // forced output direction hands the pads to the control words
  assign driveOn    = forceCtrl & ~forceDirIn;
  // low control word fills pads 0..15, high word pads 16..19
  assign ctrlWord   = {padCtrlHi, padCtrlLo};

  // address decode shared by the write and read paths
  // exact match only, so an unmapped address selects nothing
  always_comb begin
    selStatusLo   = 1'b0;
    selStatusHi   = 1'b0;
    selInputMode  = 1'b0;
    selOutputMode = 1'b0;
    selStrapVec   = 1'b0;
    unique case (mgmtReq.addr)
      `PTSR_ADDR_STATUS_LO:   selStatusLo   = 1'b1;
      `PTSR_ADDR_STATUS_HI:   selStatusHi   = 1'b1;
      `PTSR_ADDR_INPUT_MODE:  selInputMode  = 1'b1;
      `PTSR_ADDR_OUTPUT_MODE: selOutputMode = 1'b1;
      `PTSR_ADDR_STRAP_VEC:   selStrapVec   = 1'b1;
      default:                selStatusLo   = 1'b0;
    endcase
  end

  // only the mode registers take writes; status and strap words ignore them
  assign wrInputMode  = mgmtReq.wrStb & selInputMode;
  assign wrOutputMode = mgmtReq.wrStb & selOutputMode;

  // per-pad synchroniser, agreement filter and forced drive
  // a level moves only when stages two and three agree, so a one-clock glitch is lost
  genvar gi;
  generate
    for (gi = 0; gi < `PTSR_PAD_COUNT; gi = gi + 1) begin : gPad
      // three flip-flops in a row; nothing else reads the first one
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          padMeta[gi]  <= `PTSR_BIT_ZERO;
          padSyncA[gi] <= `PTSR_BIT_ZERO;
          padSyncB[gi] <= `PTSR_BIT_ZERO;
        end else begin
          padMeta[gi]  <= padIn[gi];
          padSyncA[gi] <= padMeta[gi];
          padSyncB[gi] <= padSyncA[gi];
        end
      end

      // agreement filter on stages two and three
      // costs one clock of latency, traded for a clean level
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          padLevel[gi] <= `PTSR_BIT_ZERO;
        end else if (padSyncA[gi] == padSyncB[gi]) begin
          padLevel[gi] <= padSyncB[gi];
        end
      end

      // forced output drive; enable low only while the pad is driven
      // outside forced output the pad stays released so no pin is fought
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          padOut[gi]  <= `PTSR_BIT_ZERO;
          padOe_n[gi] <= `PTSR_PAD_RELEASED;
        end else begin
          padOut[gi]  <= ctrlWord[gi];
          padOe_n[gi] <= ~driveOn;
        end
      end
    end
  endgenerate

  // low status word, one flop per bit, updated only in forced input
  // reserved positions never follow a pin, so nothing can leak onto them
  generate
    for (gi = 0; gi < `PTSR_LO_COUNT; gi = gi + 1) begin : gStatusLo
      if (gi == `PTSR_LO_RSVD_A || gi == `PTSR_LO_RSVD_B) begin : gRsvd
        // reserved bit held at zero
        always_ff @(posedge sys_clk or posedge rst) begin
          if (rst) begin
            statusLo[gi] <= `PTSR_BIT_ZERO;
          end else begin
            statusLo[gi] <= `PTSR_BIT_ZERO;
          end
        end
      end else begin : gUsed
        // mirrors its pad; holds the last level once test mode ends
        always_ff @(posedge sys_clk or posedge rst) begin
          if (rst) begin
            statusLo[gi] <= `PTSR_BIT_ZERO;
          end else if (readbackOn) begin
            statusLo[gi] <= padLevel[gi];
          end
        end
      end
    end
  endgenerate

  // high status word: rxd1..3 and strap1 in its low bits
  generate
    for (gi = 0; gi < `PTSR_HI_COUNT; gi = gi + 1) begin : gStatusHi
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          statusHi[gi] <= `PTSR_BIT_ZERO;
        end else if (readbackOn) begin
          statusHi[gi] <= padLevel[`PTSR_LO_COUNT + gi];
        end
      end
    end
  endgenerate

  // upper high status bits are reserved and read zero
  generate
    for (gi = `PTSR_HI_COUNT; gi < `PTSR_WORD_BITS; gi = gi + 1) begin : gHiRsvd
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          statusHi[gi] <= `PTSR_BIT_ZERO;
        end else begin
          statusHi[gi] <= `PTSR_BIT_ZERO;
        end
      end
    end
  endgenerate

  // input-mode register; a set bit puts its pad into input mode
  // bit map has no reserved positions, so the whole word is stored
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinInputMode <= `PTSR_RESET_WORD;
    end else if (wrInputMode) begin
      pinInputMode <= mgmtReq.wrData;
    end
  end

  // output-mode register; a set bit puts its pad into output mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinOutputMode <= `PTSR_RESET_WORD;
    end else if (wrOutputMode) begin
      pinOutputMode <= mgmtReq.wrData;
    end
  end

  // clock shift straps, captured only on the latch strobe
  // no management path reaches these flops, so a host write cannot disturb them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strapTxShift <= `PTSR_BIT_ZERO;
      strapRxShift <= `PTSR_BIT_ZERO;
    end else if (strapLatch) begin
      strapTxShift <= strapIn.txShift;
      strapRxShift <= strapIn.rxShift;
    end
  end

  // mac interface enable straps
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strapSerialEn <= `PTSR_BIT_ZERO;
      strapReduceEn <= `PTSR_BIT_ZERO;
    end else if (strapLatch) begin
      strapSerialEn <= strapIn.serialMacEn;
      strapReduceEn <= strapIn.reducedMacEn;
    end
  end

  // test mode field, passed through as strapped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strapTestMode <= `PTSR_FIELD3_ZERO;
    end else if (strapLatch) begin
      strapTestMode <= strapIn.testMode;
    end
  end

  // mac mode field; reserved codes are reported as strapped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strapMacMode <= `PTSR_FIELD3_ZERO;
    end else if (strapLatch) begin
      strapMacMode <= strapIn.macMode;
    end
  end

  // link role strap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strapRole <= `PTSR_BIT_ZERO;
    end else if (strapLatch) begin
      strapRole <= strapIn.link_role_strap;
    end
  end

  // management address strap; undefined values are not filtered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strapAddr <= `PTSR_ADDR5_ZERO;
    end else if (strapLatch) begin
      strapAddr <= strapIn.management_address_strap;
    end
  end

  // strap fields laid out in their read positions
  always_comb begin
    strapWord                                            = `PTSR_RESET_WORD;
    strapWord[`PTSR_STRAP_TXSH_BIT]                      = strapTxShift;
    strapWord[`PTSR_STRAP_RXSH_BIT]                      = strapRxShift;
    strapWord[`PTSR_STRAP_SERIAL_BIT]                    = strapSerialEn;
    strapWord[`PTSR_STRAP_REDUCE_BIT]                    = strapReduceEn;
    strapWord[`PTSR_STRAP_TEST_MSB:`PTSR_STRAP_TEST_LSB] = strapTestMode;
    strapWord[`PTSR_STRAP_MODE_MSB:`PTSR_STRAP_MODE_LSB] = strapMacMode;
    strapWord[`PTSR_STRAP_ROLE_BIT]                      = strapRole;
    strapWord[`PTSR_STRAP_ADDR_MSB:`PTSR_STRAP_ADDR_LSB] = strapAddr;
  end

  // read word chosen from the decoded address; unmapped addresses read zero
  always_comb begin
    next_rdData = `PTSR_RESET_WORD;
    if (selStatusLo) begin
      next_rdData = statusLo;
    end
    if (selStatusHi) begin
      next_rdData = statusHi;
    end
    if (selInputMode) begin
      next_rdData = pinInputMode;
    end
    if (selOutputMode) begin
      next_rdData = pinOutputMode;
    end
    if (selStrapVec) begin
      next_rdData = strapWord;
    end
  end

  // read data is registered and holds until the next read
  // holding it lets a slow host sample the word at leisure
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData <= `PTSR_RESET_WORD;
    end else if (mgmtReq.rdStb) begin
      rdData <= next_rdData;
    end
  end

  // read answer pulses for one cycle, one cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdValid <= `PTSR_BIT_ZERO;
    end else begin
      rdValid <= mgmtReq.rdStb;
    end
  end
endmodule

// File: rtl/ptsr_params.svh
// constants and rule summary for the pad test and strap readback block
// Operation
// - forced input mode: status bits mirror pin levels
// - low status map, bits 4,5 reserved zero
// - high status: rxd1-3, strap1, rest zero
// - input-mode register, read/write, resets zero
// - output-mode register, read/write, resets zero
// - mode registers map sixteen pins, none reserved
// - strap bits 15,14: clock shift enables
// - strap bits 13,12: serial, reduced mac enable
// - strap bits 8:6 hold mac mode
// - strap bit 5 reports link role
// - strap bits 4:0 report management address
// - force bit enters test, direction picks readback
// - forced output drives pins from control bits
`ifndef PTSR_PARAMS_SVH
`define PTSR_PARAMS_SVH
`define PTSR_ADDR_STATUS_LO   16'h0457
`define PTSR_ADDR_STATUS_HI   16'h0458
`define PTSR_ADDR_INPUT_MODE  16'h0459
`define PTSR_ADDR_OUTPUT_MODE 16'h045A
`define PTSR_ADDR_STRAP_VEC   16'h045D
`define PTSR_RESET_WORD       16'h0000
`define PTSR_LO_RSVD_MASK     16'hFFCF
`define PTSR_HI_USED_MASK     16'h000F
`define PTSR_PAD_COUNT        20
`define PTSR_LO_COUNT         16
`define PTSR_HI_COUNT         4
`define PTSR_WORD_BITS        16
`define PTSR_LO_RSVD_A        4
`define PTSR_LO_RSVD_B        5
`define PTSR_BIT_ZERO         1'b0
`define PTSR_PAD_RELEASED     1'b1
`define PTSR_FIELD3_ZERO      3'h0
`define PTSR_ADDR5_ZERO       5'h00
`define PTSR_STRAP_TXSH_BIT   15
`define PTSR_STRAP_RXSH_BIT   14
`define PTSR_STRAP_SERIAL_BIT 13
`define PTSR_STRAP_REDUCE_BIT 12
`define PTSR_STRAP_TEST_MSB   11
`define PTSR_STRAP_TEST_LSB   9
`define PTSR_STRAP_MODE_MSB   8
`define PTSR_STRAP_MODE_LSB   6
`define PTSR_STRAP_ROLE_BIT   5
`define PTSR_STRAP_ADDR_MSB   4
`define PTSR_STRAP_ADDR_LSB   0
`endif

// File: rtl/ptsr_pkg.sv
// types shared by the pad test and strap readback block
package ptsr_pkg;
  typedef struct packed {
    logic       txShift;
    logic       rxShift;
    logic       serialMacEn;
    logic       reducedMacEn;
    logic [2:0] testMode;
    logic [2:0] macMode;
    logic       link_role_strap;
    logic [4:0] management_address_strap;
  } ptsr_strap_t;
  typedef struct packed {
    logic        wrStb;
    logic        rdStb;
    logic [15:0] addr;
    logic [15:0] wrData;
  } ptsr_mgmt_req_t;
  typedef enum logic [2:0] {
    PTSR_MAC_SERIAL  = 3'h0,
    PTSR_MAC_ALIGN   = 3'h4,
    PTSR_MAC_TXSH    = 3'h5,
    PTSR_MAC_TXRXSH  = 3'h6,
    PTSR_MAC_RXSH    = 3'h7
  } ptsr_mac_mode_t;
endpackage

// File: tb/ptsr_pad_test_strap_properties.sv
// port assertions for the pad test and strap readback block
`timescale 1ns/1ps
module ptsr_checker (
  input wire logic                     sys_clk,
  input wire logic                     rst,
  input wire ptsr_pkg::ptsr_mgmt_req_t mgmtReq,
  input wire logic [15:0]              rdData,
  input wire logic                     rdValid,
  input wire logic                     forceCtrl,
  input wire logic                     forceDirIn,
  input wire logic [19:0]              padOe_n,
  input wire logic [15:0]              pinInputMode,
  input wire logic [15:0]              pinOutputMode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rv; mgmtReq.rdStb |=> rdValid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_wi; mgmtReq.wrStb && mgmtReq.addr == 16'h0459 |=> pinInputMode == $past(mgmtReq.wrData); endproperty
  a_wi: assert property (p_wi) else $error("input mode write lost");
  property p_wo; mgmtReq.wrStb && mgmtReq.addr == 16'h045A |=> pinOutputMode == $past(mgmtReq.wrData); endproperty
  a_wo: assert property (p_wo) else $error("output mode write lost");
  property p_ri; mgmtReq.rdStb && mgmtReq.addr == 16'h0459 |=> rdData == $past(pinInputMode); endproperty
  a_ri: assert property (p_ri) else $error("input mode read wrong");
  property p_hi; mgmtReq.rdStb && mgmtReq.addr == 16'h0458 |=> rdData[15:4] == 12'h000; endproperty
  a_hi: assert property (p_hi) else $error("high status reserved set");
  property p_lo; mgmtReq.rdStb && mgmtReq.addr == 16'h0457 |=> rdData[5:4] == 2'h0; endproperty
  a_lo: assert property (p_lo) else $error("low status reserved set");
  property p_dr; forceCtrl && !forceDirIn |=> padOe_n == 20'h00000; endproperty
  a_dr: assert property (p_dr) else $error("forced output not driving");
  property p_rl; !forceCtrl |=> &padOe_n; endproperty
  a_rl: assert property (p_rl) else $error("pad driven outside test");
  c_rd: cover property (mgmtReq.rdStb && mgmtReq.addr == 16'h0457);
  c_fi: cover property (forceCtrl && forceDirIn);
  c_fo: cover property (forceCtrl && !forceDirIn);
endmodule
bind ptsr_pad_test_strap ptsr_checker chk_u (.sys_clk, .rst, .mgmtReq, .rdData, .rdValid, .forceCtrl,
  .forceDirIn, .padOe_n, .pinInputMode, .pinOutputMode);

// File: tb/ptsr_pad_test_strap_tb_top.sv
// self-checking bench for the pad test and strap readback block
`timescale 1ns/1ps
module ptsr_pad_test_strap_tb_top;
  logic                     sys_clk = 0, rst = 1, rdValid, forceCtrl = 0, forceDirIn = 0, strapLatch = 0;
  logic [15:0]              rdData, pinInputMode, pinOutputMode, w, padCtrlLo = 0;
  logic [3:0]               padCtrlHi = 0;
  logic [19:0]              padIn, padOut, padOe_n, extLvl = 0;
  ptsr_pkg::ptsr_mgmt_req_t mgmtReq = '0;
  ptsr_pkg::ptsr_strap_t    strapIn = '0;
  int                       failures = 0, total_checks = 0, seed = 63341, cyc = 0, i;
  ptsr_pad_test_strap dut_u (.sys_clk, .rst, .mgmtReq, .rdData, .rdValid, .forceCtrl, .forceDirIn, .padCtrlLo,
    .padCtrlHi, .padIn, .padOut, .padOe_n, .strapIn, .strapLatch, .pinInputMode, .pinOutputMode);
  ptsr_pin_model pins_u (.padOut, .padOe_n, .extLvl, .padIn);
  initial forever #2 sys_clk = ~sys_clk;
  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge sys_clk) if (++cyc > 2000) begin
    failures++;
    finish_test();
  end
  task chk(string n, logic [19:0] e, logic [19:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // expected status words from board levels, reserved bits low
  function automatic logic [15:0] exp_lo(logic [19:0] lvl);
    return lvl[15:0] & 16'hFFCF;
  endfunction
  function automatic logic [15:0] exp_hi(logic [19:0] lvl);
    return {12'h000, lvl[19:16]};
  endfunction
  // one-cycle strobe; read answer is sampled in the cycle it stands
  task acc(logic wr, logic [15:0] a, logic [15:0] d);
    @(negedge sys_clk) mgmtReq <= '{wr, !wr, a, d};
    @(negedge sys_clk) mgmtReq <= '0;
  endtask
  task rd(logic [15:0] a, logic [15:0] e);
    acc(0, a, 16'h0000);
    chk("read", {4'h1, e}, {3'h0, rdValid, rdData});
  endtask
  task finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) rst <= 0;
    acc(1, 16'h045D, 16'hFFFF);
    acc(1, 16'h0458, 16'hFFFF);
    for (i = 16'h0457; i < 16'h045E; i++) rd(16'(i), 16'h0000);
    $display("reset words done");
    repeat (4) begin
      w = 16'($random(seed));
      acc(1, 16'h0459, w);
      acc(1, 16'h045A, ~w);
      rd(16'h0459, w);
      rd(16'h045A, ~w);
      chk("inmode", {4'h0, w}, pinInputMode);
      chk("outmode", {4'h0, ~w}, pinOutputMode);
    end
    @(negedge sys_clk) rst <= 1;
    @(negedge sys_clk) rst <= 0;
    chk("inmode", 20'h00000, pinInputMode);
    chk("outmode", 20'h00000, pinOutputMode);
    rd(16'h0459, 16'h0000);
    $display("mode registers done");
    for (i = 0; i < 8; i++) begin
      w = 16'($random(seed));
      w[8:6] = 3'(i);
      strapIn <= w;
      strapLatch <= 1;
      @(negedge sys_clk) strapLatch <= 0;
      rd(16'h045D, w);
    end
    $display("strap vector done");
    extLvl = 20'($random(seed));
    forceCtrl <= 1;
    forceDirIn <= 1;
    repeat (6) @(negedge sys_clk);
    rd(16'h0457, exp_lo(extLvl));
    rd(16'h0458, exp_hi(extLvl));
    {padCtrlHi, padCtrlLo} <= ~extLvl;
    forceDirIn <= 0;
    repeat (3) @(negedge sys_clk);
    chk("pins", ~extLvl, padIn);
    chk("oe", 20'h00000, padOe_n);
    $display("pad test done");
    finish_test();
  end
endmodule

// File: tb/ptsr_pin_model.sv
// pin-side model: resolves each pad from device drive or board level
`timescale 1ns/1ps
module ptsr_pin_model (
  input  wire logic [19:0] padOut,
  input  wire logic [19:0] padOe_n,
  input  wire logic [19:0] extLvl,
  output logic      [19:0] padIn
);
  // the board level wins only where the device has let go of the pad
  assign padIn = (padOut & ~padOe_n) | (extLvl & padOe_n);
endmodule
